/* design/jog_and_bit_speed_select.sv */
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module jog_and_bit_speed_select
    import jog_speed_pkg::*;
#(
    parameter int STEP_CYCLES_P = STEP_CYCLES
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              jog_input,
    input  wire logic              forward_run_input,
    input  wire logic              reverse_run_input,
    input  wire logic              panel_run_key,
    input  wire logic [NUM_BITS-1:0] bit_speed_inputs,
    input  wire logic              store_key,
    input  wire logic [FREQ_W-1:0] displayed_frequency,
    output logic      [FREQ_W-1:0] output_frequency,
    output logic                   running,
    output logic                   reverse_dir,
    output logic                   free_run_stop,
    output logic                   dc_injection_braking,
    output logic      [2:0]        selected_speed
);
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] A_JOG_FREQ  = 8'h00;
    localparam logic [7:0] A_STOP_SEL  = 8'h04;
    localparam logic [7:0] A_OUT_FREQ  = 8'h08;
    localparam logic [7:0] A_RUN_SRC   = 8'h0c;
    localparam logic [7:0] A_MAX_FREQ  = 8'h10;
    localparam logic [7:0] A_SETTLE    = 8'h14;
    localparam logic [7:0] A_START_FRQ = 8'h18;
    localparam logic [7:0] A_DB_TIME   = 8'h1c;
    localparam logic [7:0] A_DEC_STEP  = 8'h20;
    localparam logic [7:0] A_STATUS    = 8'h24;
    localparam logic [7:0] A_TABLE     = 8'h40;  // Eight words, one per speed

    logic [FREQ_W-1:0] jog_frequency_setting;
    logic [2:0]        jog_stop_selection;
    logic [FREQ_W-1:0] output_frequency_setting;
    logic [1:0]        run_command_source;
    logic [FREQ_W-1:0] maximum_frequency_setting;
    logic [7:0]        speed_select_settle_time;
    logic [FREQ_W-1:0] start_frequency;
    logic [FREQ_W-1:0] db_time;
    logic [FREQ_W-1:0] decel_step;
    logic [FREQ_W-1:0] multi_speed_table [NUM_SPEEDS];

    // Clamp helper: keeps a value between two limits
    function automatic logic [FREQ_W-1:0] clamp(input logic [FREQ_W-1:0] v,
                                                 input logic [FREQ_W-1:0] lo,
                                                 input logic [FREQ_W-1:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Lowest active input wins, all off gives speed 0
    function automatic logic [2:0] bit_decode(input logic [NUM_BITS-1:0] b);
        bit_decode = 3'h0;
        for (int i = NUM_BITS - 1; i >= 0; i--) begin
            if (b[i]) begin
                bit_decode = 3'(i + 1);
            end
        end
    endfunction

    wire logic wr_en = psel && penable && pwrite;
    wire logic rd_en = psel && !penable && !pwrite;
    wire logic table_hit = (paddr[7:5] == A_TABLE[7:5]) && (paddr[1:0] == 2'h0);

    // ****************************************************************
    // Speed select settling
    // ****************************************************************
    logic [NUM_BITS-1:0] last_bits, next_last_bits;
    logic [7:0]          settle_steps, next_settle_steps;
    logic [31:0]         tick_cnt, next_tick_cnt;
    logic [2:0]          next_selected_speed;
    logic [2:0]          edit_speed, next_edit_speed;

    // A pattern change restarts the mask; the speed is taken only after it expires
    always_comb begin
        next_last_bits      = bit_speed_inputs;
        next_settle_steps   = settle_steps;
        next_tick_cnt       = tick_cnt;
        next_selected_speed = selected_speed;
        if (bit_speed_inputs != last_bits) begin
            next_settle_steps = 8'h00;
            next_tick_cnt     = 32'h0;
        end else if (settle_steps >= speed_select_settle_time) begin
            next_selected_speed = bit_decode(bit_speed_inputs);
        end else if (tick_cnt == 32'(STEP_CYCLES_P - 1)) begin
            next_tick_cnt     = 32'h0;
            next_settle_steps = settle_steps + 8'h01;
        end else begin
            next_tick_cnt = tick_cnt + 32'h1;
        end
        // Speed of the last cycle; a store in the cycle the speed moves is dropped
        next_edit_speed = selected_speed;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_bits      <= '0;
            settle_steps   <= 8'h00;
            tick_cnt       <= 32'h0;
            selected_speed <= 3'h0;
            edit_speed     <= 3'h0;
        end else begin
            last_bits      <= next_last_bits;
            settle_steps   <= next_settle_steps;
            tick_cnt       <= next_tick_cnt;
            selected_speed <= next_selected_speed;
            edit_speed     <= next_edit_speed;
        end
    end

    // ****************************************************************
    // Configuration registers and speed table
    // ****************************************************************
    // The edit is only committed on a store press while the same speed stays selected
    wire logic store_now = store_key && (edit_speed == selected_speed);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jog_frequency_setting     <= JOG_FREQ_RST;
            jog_stop_selection        <= STOP_SEL_RST;
            output_frequency_setting  <= '0;
            run_command_source        <= 2'h0;
            maximum_frequency_setting <= MAX_FREQ_RST;
            speed_select_settle_time  <= 8'h00;
            start_frequency           <= START_FREQ_RST;
            db_time                   <= DB_TIME_RST;
            decel_step                <= DECEL_STEP_RST;
            for (int i = 0; i < NUM_SPEEDS; i++) begin
                multi_speed_table[i] <= '0;
            end
        end else begin
            if (store_now) begin
                multi_speed_table[selected_speed] <= displayed_frequency;
            end
            if (wr_en) begin
                unique case (paddr)
                    A_JOG_FREQ: jog_frequency_setting <=
                        clamp(pwdata[15:0], start_frequency, JOG_FREQ_MAX);
                    A_STOP_SEL: if (pwdata[2:0] <= STOP_DB_RUN) begin
                        jog_stop_selection <= pwdata[2:0];
                    end
                    A_OUT_FREQ:  output_frequency_setting  <= pwdata[15:0];
                    A_RUN_SRC:   run_command_source        <= pwdata[1:0];
                    A_MAX_FREQ:  maximum_frequency_setting <= pwdata[15:0];
                    A_SETTLE:    speed_select_settle_time  <=
                        (pwdata[7:0] > SETTLE_MAX) ? SETTLE_MAX : pwdata[7:0];
                    A_START_FRQ: start_frequency <= pwdata[15:0];
                    A_DB_TIME:   db_time         <= pwdata[15:0];
                    A_DEC_STEP:  decel_step      <= pwdata[15:0];
                    default: if (table_hit && !store_now) begin
                        multi_speed_table[paddr[4:2]] <= pwdata[15:0];
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Jog and run control
    // ****************************************************************
    drive_state_t      state, next_state;
    logic [FREQ_W-1:0] next_output_frequency;
    logic [FREQ_W-1:0] db_cnt, next_db_cnt;
    logic              next_reverse_dir;
    logic              jog_req;
    logic              run_cmd;
    logic              stop_locked;
    logic [FREQ_W-1:0] jog_target;

    always_comb begin
        run_cmd     = forward_run_input || reverse_run_input;
        // Panel run key counts as jog trigger only from terminal source
        jog_req     = jog_input && (run_cmd ||
                      (panel_run_key && run_command_source == SRC_TERMINAL));
        stop_locked = jog_stop_selection <= STOP_DB;
        // Output setting overrides jog speed while jogging, still within the jog cap
        jog_target  = (output_frequency_setting != '0) ?
                      clamp(output_frequency_setting, start_frequency, JOG_FREQ_MAX) :
                      jog_frequency_setting;
        next_state            = state;
        next_output_frequency = output_frequency;
        next_db_cnt           = db_cnt;
        next_reverse_dir      = reverse_dir;
        unique case (state)
            ST_IDLE: begin
                if (jog_req) begin
                    next_state            = ST_JOG;
                    next_output_frequency = jog_target;
                    next_reverse_dir      = reverse_run_input;
                end else if (run_cmd) begin
                    next_state            = ST_RUN;
                    next_reverse_dir      = reverse_run_input;
                    next_output_frequency = clamp(multi_speed_table[selected_speed], '0,
                                                  maximum_frequency_setting);
                end
            end
            ST_RUN: begin
                next_output_frequency = clamp(multi_speed_table[selected_speed], '0,
                                              maximum_frequency_setting);
                if (!run_cmd) begin
                    next_state            = ST_IDLE;
                    next_output_frequency = '0;
                end else if (jog_input && !stop_locked) begin
                    next_state            = ST_JOG;
                    next_output_frequency = jog_target;
                end
            end
            ST_JOG: begin
                next_output_frequency = jog_target;
                // Ends when its trigger goes, so a panel key jog holds as well
                if (!jog_req) begin
                    unique case (jog_stop_selection)
                        STOP_DEC, STOP_DEC_RUN: next_state = ST_DECEL;
                        STOP_DB, STOP_DB_RUN: begin
                            next_state            = ST_DCBRK;
                            next_db_cnt           = db_time;
                            next_output_frequency = '0;
                        end
                        default: begin
                            next_state            = ST_COAST;
                            next_output_frequency = '0;
                        end
                    endcase
                end
            end
            ST_DECEL: begin
                if (output_frequency <= decel_step) begin
                    next_output_frequency = '0;
                    next_state            = ST_IDLE;
                end else begin
                    next_output_frequency = output_frequency - decel_step;
                end
            end
            ST_DCBRK: begin
                if (db_cnt == '0) begin
                    next_state = ST_IDLE;
                end else begin
                    next_db_cnt = db_cnt - 16'h0001;
                end
            end
            ST_COAST: begin
                // Coast ends once all run requests are released
                if (!run_cmd && !jog_input) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                <= ST_IDLE;
            output_frequency     <= '0;
            db_cnt               <= '0;
            reverse_dir          <= 1'b0;
            running              <= 1'b0;
            free_run_stop        <= 1'b0;
            dc_injection_braking <= 1'b0;
        end else begin
            state                <= next_state;
            output_frequency     <= next_output_frequency;
            db_cnt               <= next_db_cnt;
            reverse_dir          <= next_reverse_dir;
            running              <= (next_state == ST_JOG) || (next_state == ST_RUN) ||
                                    (next_state == ST_DECEL);
            free_run_stop        <= next_state == ST_COAST;
            dc_injection_braking <= next_state == ST_DCBRK;
        end
    end

    // ****************************************************************
    // APB read path, zero wait states
    // ****************************************************************
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h0;
        unique case (paddr)
            A_JOG_FREQ:  next_prdata[15:0] = jog_frequency_setting;
            A_STOP_SEL:  next_prdata[2:0]  = jog_stop_selection;
            A_OUT_FREQ:  next_prdata[15:0] = output_frequency_setting;
            A_RUN_SRC:   next_prdata[1:0]  = run_command_source;
            A_MAX_FREQ:  next_prdata[15:0] = maximum_frequency_setting;
            A_SETTLE:    next_prdata[7:0]  = speed_select_settle_time;
            A_START_FRQ: next_prdata[15:0] = start_frequency;
            A_DB_TIME:   next_prdata[15:0] = db_time;
            A_DEC_STEP:  next_prdata[15:0] = decel_step;
            A_STATUS:    next_prdata[9:0]  = {selected_speed, running, state, free_run_stop,
                                              dc_injection_braking, reverse_dir};
            default: if (table_hit) begin
                next_prdata[15:0] = multi_speed_table[paddr[4:2]];
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            if (rd_en) begin
                prdata <= next_prdata;
            end
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* design/jog_speed_pkg.sv */
// Overview of operation
// - The drive jogs at the jog frequency while the jog input is on together with a run input or the panel run key; dropping it stops the jog.
// - The jog frequency setting is held between the start frequency and 9.99 Hz, default 6.00 Hz.
// - Jog steps the output straight to the jog frequency with no ramp.
// - The jog stop selection decodes six stop methods, default 04.
// - With stop selection 0, 1 or 2 a jog request while already running is ignored.
// - Stop selection 02 or 05 ends the jog with the configured DC braking.
// - During jog the output frequency setting may change the output frequency.
// - The panel run key triggers a jog only when the run command source is 01.
// - In bit mode each of the seven speed inputs takes part in choosing the speed.
// - One store key press writes the displayed frequency into the selected speed entry.
// - Moving to another speed without storing discards the edit.
// - Every multi-speed value is limited to the maximum frequency setting.
// - The lowest active speed input wins; all off selects speed 0.
// - A changed speed input pattern is acted on only after the settle time in 10 ms steps.
package jog_speed_pkg;
    localparam int          FREQ_W        = 16;     // Frequency in 0.01 Hz units
    localparam int          NUM_SPEEDS    = 8;
    localparam int          NUM_BITS      = 7;
    localparam logic [15:0] JOG_FREQ_MAX  = 16'h03e7; // 9.99 Hz
    localparam logic [15:0] JOG_FREQ_RST  = 16'h0258; // 6.00 Hz
    localparam logic [15:0] START_FREQ_RST = 16'h0032; // 0.50 Hz
    localparam logic [15:0] MAX_FREQ_RST  = 16'h1388; // 50.00 Hz
    localparam logic [15:0] DECEL_STEP_RST = 16'h0001;
    localparam logic [2:0]  STOP_FRS      = 3'h0;
    localparam logic [2:0]  STOP_DEC      = 3'h1;
    localparam logic [2:0]  STOP_DB       = 3'h2;
    localparam logic [2:0]  STOP_FRS_RUN  = 3'h3;
    localparam logic [2:0]  STOP_DEC_RUN  = 3'h4;
    localparam logic [2:0]  STOP_DB_RUN   = 3'h5;
    localparam logic [2:0]  STOP_SEL_RST  = 3'h4;
    localparam logic [1:0]  SRC_TERMINAL  = 2'h1;
    localparam logic [7:0]  SETTLE_MAX    = 8'hc8;  // 200 steps
    localparam int          SETTLE_STEP_MS = 10;
    localparam int          CLK_HZ        = 25000000;
    localparam int          STEP_CYCLES   = CLK_HZ / 1000 * SETTLE_STEP_MS;
    localparam logic [15:0] DB_TIME_RST   = 16'h0064;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_JOG    = 3'b001,
        ST_RUN    = 3'b010,
        ST_DECEL  = 3'b011,
        ST_DCBRK  = 3'b100,
        ST_COAST  = 3'b101
    } drive_state_t;
endpackage

/* verification/jog_speed_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module jog_speed_monitor
    import jog_speed_pkg::*;
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                jog_input,
    input wire logic                forward_run_input,
    input wire logic                reverse_run_input,
    input wire logic [NUM_BITS-1:0] bit_speed_inputs,
    input wire logic [FREQ_W-1:0]   output_frequency,
    input wire logic                running,
    input wire logic                free_run_stop,
    input wire logic                dc_injection_braking,
    input wire logic [2:0]          selected_speed
);
    // Lowest numbered active input wins
    function automatic logic [2:0] prio(input logic [6:0] b);
        prio = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (b[i]) begin
                prio = 3'(i + 1);
            end
        end
    endfunction

    logic idle;
    logic any_cmd;
    // Helpers keep the properties short
    assign idle = !running && !free_run_stop && !dc_injection_braking;
    assign any_cmd = jog_input || forward_run_input || reverse_run_input;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    jog_start_a: assert property (
        idle && jog_input && forward_run_input |-> ##[1:3] running)
        else $error("jog did not start");
    jog_limit_a: assert property (
        $rose(running) && jog_input |-> ##1 output_frequency <= JOG_FREQ_MAX)
        else $error("jog output above limit");
    decel_down_a: assert property (
        running && !any_cmd |=> output_frequency <= $past(output_frequency))
        else $error("output rose after release");
    coast_idle_a: assert property (
        free_run_stop |-> !running && !dc_injection_braking)
        else $error("coast overlaps another state");
    brake_idle_a: assert property (
        dc_injection_braking |-> !running)
        else $error("braking while running");
    coast_hold_a: assert property (
        free_run_stop && any_cmd |=> free_run_stop && !running)
        else $error("coast left while commands on");
    settle_hold_a: assert property (
        $changed(selected_speed) |-> $stable(bit_speed_inputs))
        else $error("speed taken before settling");
    speed_prio_a: assert property (
        $changed(selected_speed) |-> selected_speed == prio(bit_speed_inputs))
        else $error("wrong speed chosen");
endmodule

bind jog_and_bit_speed_select jog_speed_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .jog_input(jog_input),
    .forward_run_input(forward_run_input), .reverse_run_input(reverse_run_input),
    .bit_speed_inputs(bit_speed_inputs), .output_frequency(output_frequency),
    .running(running), .free_run_stop(free_run_stop),
    .dc_injection_braking(dc_injection_braking), .selected_speed(selected_speed)
);
`default_nettype wire

/* verification/jog_switch_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Terminal switches of an outside controller
// ****
module jog_switch_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic want_jog,
    input  wire logic want_run,
    input  wire logic want_rev,
    output logic      jog_input,
    output logic      forward_run_input,
    output logic      reverse_run_input
);
    logic run_ok;
    // While jog is wanted, a run line may rise only once the jog line already stands high
    assign run_ok = want_run && (!want_jog || jog_input);

    // Lines change just after the edge; a held run line stays up when jog joins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jog_input         <= 1'b0;
            forward_run_input <= 1'b0;
            reverse_run_input <= 1'b0;
        end else begin
            jog_input         <= want_jog;
            forward_run_input <= !want_rev && (run_ok || (want_run && forward_run_input));
            reverse_run_input <= want_rev && (run_ok || (want_run && reverse_run_input));
        end
    end
endmodule
`default_nettype wire

/* verification/jog_and_bit_speed_select_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module jog_and_bit_speed_select_tb
    import jog_speed_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        want_jog, want_run, want_rev, panel_run_key, store_key;
    logic        running, free_run_stop, dc_injection_braking, reverse_dir;
    logic        jog_input, forward_run_input, reverse_run_input;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0]  bit_speed_inputs;
    logic [15:0] displayed_frequency, output_frequency;
    logic [2:0]  selected_speed;
    logic [15:0] tbl [8];
    int          n_mismatch, compares, cycles;

    // Bus clock, 40 ns period
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Short settle step keeps the run brief
    jog_and_bit_speed_select #(.STEP_CYCLES_P(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .jog_input(jog_input), .forward_run_input(forward_run_input),
        .reverse_run_input(reverse_run_input), .panel_run_key(panel_run_key),
        .bit_speed_inputs(bit_speed_inputs), .store_key(store_key),
        .displayed_frequency(displayed_frequency), .output_frequency(output_frequency),
        .running(running), .reverse_dir(reverse_dir), .free_run_stop(free_run_stop),
        .dc_injection_braking(dc_injection_braking), .selected_speed(selected_speed)
    );
    jog_switch_model sw_u (
        .pclk(pclk), .presetn(presetn), .want_jog(want_jog), .want_run(want_run),
        .want_rev(want_rev), .jog_input(jog_input), .forward_run_input(forward_run_input),
        .reverse_run_input(reverse_run_input)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, e);
        check(32'({pready, pslverr}), 32'h2);
    endtask

    // Lowest numbered active input wins, all off gives speed 0
    function automatic logic [2:0] prio(input logic [6:0] b);
        prio = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (b[i]) begin
                prio = 3'(i + 1);
            end
        end
    endfunction

    // Request through the switch model; six cycles cover its extra stage
    task automatic go(input logic j, input logic r);
        want_jog <= j;
        want_run <= r;
        repeat (6) @(posedge pclk);
    endtask

    // Release all, note which stop kinds appear, bounded wait for idle
    task automatic halt(output logic sf, output logic sd);
        want_jog <= 1'b0;
        want_run <= 1'b0;
        panel_run_key <= 1'b0;
        sf = 1'b0;
        sd = 1'b0;
        repeat (1500) begin
            @(posedge pclk);
            sf = sf | free_run_stop;
            sd = sd | dc_injection_braking;
            if (!running && !free_run_stop && !dc_injection_braking) begin
                break;
            end
        end
        check(32'({running, free_run_stop, dc_injection_braking}), 32'h0);
    endtask

    // Cycle ceiling cuts a hang short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        logic [31:0] f;
        logic        sf;
        logic        sd;
        logic [6:0]  b;
        logic [2:0]  sp;
        {psel, penable, pwrite, want_jog, want_run, want_rev, panel_run_key, store_key} = '0;
        {paddr, pwdata, bit_speed_inputs, displayed_frequency} = '0;
        {n_mismatch, compares, cycles} = '0;
        presetn = 1'b0;
        f = $urandom(2394);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(8'h00, 32'h258);
        rdchk(8'h04, 32'h4);
        rdchk(8'h10, 32'h1388);
        rdchk(8'h30, 32'h0);
        wr(8'h00, 32'h3e8);
        rdchk(8'h00, 32'h3e7);
        wr(8'h00, 32'h10);
        rdchk(8'h00, 32'h32);
        wr(8'h14, 32'h1);
        wr(8'h1c, 32'h3);
        wr(8'h0c, 32'h1);
        for (int k = 0; k < 8; k++) begin
            tbl[k] = 16'h200 + 16'(k);
            wr(8'h40 + 8'(4 * k), 32'(tbl[k]));
        end
        // Every stop method; coast kinds also see run dropped while jog stays
        for (int s = 0; s < 6; s++) begin
            f = 32'h32 + $urandom_range(32'h1c2);
            wr(8'h04, 32'(s));
            wr(8'h00, f);
            want_rev <= s[0];
            go(1'b1, 1'b1);
            check(32'(output_frequency), f);
            check(32'(reverse_dir), 32'(s[0]));
            if (s % 3 == 0) begin
                go(1'b1, 1'b0);
                check(32'(running), 32'h0);
            end
            halt(sf, sd);
            check(32'(sf), 32'(s % 3 == 0));
            check(32'(sd), 32'(s % 3 == 2));
        end
        go(1'b1, 1'b1);
        wr(8'h08, 32'h64);
        repeat (3) @(posedge pclk);
        check(32'(output_frequency), 32'h64);
        halt(sf, sd);
        wr(8'h08, 32'h0);
        for (int src = 0; src < 2; src++) begin
            wr(8'h0c, 32'(src));
            panel_run_key <= 1'b1;
            go(1'b1, 1'b0);
            check(32'(running), 32'(src));
            halt(sf, sd);
        end
        wr(8'h04, 32'h1);
        go(1'b0, 1'b1);
        check(32'(output_frequency), 32'(tbl[0]));
        go(1'b1, 1'b1);
        check(32'(output_frequency), 32'(tbl[0]));
        halt(sf, sd);
        wr(8'h10, 32'h180);
        go(1'b0, 1'b1);
        check(32'(output_frequency), 32'h180);
        halt(sf, sd);
        wr(8'h10, 32'h1388);
        // Speed patterns; odd passes store, even passes edit and move on
        sp = 3'h0;
        for (int i = 0; i < 10; i++) begin
            b = (i == 0) ? 7'h7f : 7'($urandom) & (7'h7f << (i % 8));
            bit_speed_inputs <= b;
            repeat (2) @(posedge pclk);
            check(32'(selected_speed), 32'(sp));
            sp = prio(b);
            repeat (12) @(posedge pclk);
            check(32'(selected_speed), 32'(sp));
            displayed_frequency <= 16'($urandom_range(32'h1388));
            store_key <= i[0];
            @(posedge pclk);
            store_key <= 1'b0;
            if (i[0]) begin
                tbl[sp] = displayed_frequency;
            end
            rdchk(8'h40 + 8'({sp, 2'b00}), 32'(tbl[sp]));
        end
        print_verdict();
    end
endmodule
`default_nettype wire
